/* verilog/sleep_wake_interrupt_control.sv */
// sleep instruction handling, wake-up sequencing and watchdog with apb access
//
// Function
// - pending means enabled flag set, global enable clear
// - pending before sleep makes sleep a no-op
// - skipped sleep keeps watchdog, postscaler, status flags
// - pending during sleep: finish sleep, wake at once (rc) or after the 1024-cycle start-up wait (crystal)
// - real sleep clears watchdog, sets timeout, clears powerdown
// - powerdown flag stays set after skipped sleep
// - wake resumes next instruction, vectors if enabled
// - sleep prefetches next sequential instruction
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_interrupt_control
   import sleep_wake_pkg::*;
#(
   parameter int wdt_cycles = wdt_period_cyc
)
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic                        pready,
   output logic                        pslverr,
   output logic [31:0]                 prdata,
   input  wire logic [num_sources-1:0] irq_event,
   input  wire logic                   sleep_exec,
   input  wire logic                   clrwdt_exec,
   output logic                        prefetch_next,
   output logic                        resume_next,
   output logic                        branch_vector,
   output logic                        watchdog_reset,
   output logic                        core_hold
);

   state_type s;
   state_type next_s;

   logic wake_cond;
   logic nop_cond;
   logic wdt_wrap;
   logic wdt_timeout;
   logic wr_take;
   logic rd_start;

   // divide ratio of the postscaler as a terminal count
   function automatic logic [7:0] ps_limit(input logic [2:0] sel);
      logic [7:0] one_hot;
      one_hot = 8'h01 << sel;
      return one_hot - 8'h01;
   endfunction

   // read mux of the register file
   function automatic logic [31:0] read_reg(input logic [7:0] a,
                                            input state_type st);
      logic [31:0] v;
      v = 32'h0;
      if (a == ctrl_addr)
      begin
         v[ctrl_gie_bit] = st.global_interrupt_enable;
         v[ctrl_ie_lsb +: num_sources] = st.enable;
         v[ctrl_crystal_bit] = st.crystal;
         v[ctrl_wdt_en_bit] = st.wdt_en;
         v[ctrl_ps_lsb +: 3] = st.ps_sel;
      end
      else if (a == flag_addr)
      begin
         v[num_sources-1:0] = st.flag;
      end
      else if (a == status_addr)
      begin
         v[stat_timeout_bit] = st.timeout_status_flag;
         v[stat_powerdown_bit] = st.powerdown_status_flag;
         v[stat_sleeping_bit] = (st.phase != awake);
         v[stat_skipped_bit] = st.skipped;
      end
      else if (a == wdt_addr)
      begin
         v[17:0] = st.watchdog_counter;
      end
      return v;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a == ctrl_addr) || (a == flag_addr) ||
             (a == status_addr) || (a == wdt_addr);
   endfunction

   // any enabled source flagged wakes the core
   assign wake_cond = |(s.enable & s.flag);
   // same condition with interrupts globally off skips the sleep
   assign nop_cond = wake_cond && !s.global_interrupt_enable;

   assign wdt_wrap = s.wdt_en &&
                     (s.watchdog_counter == 18'(wdt_cycles - 1));
   assign wdt_timeout = wdt_wrap && (s.postscaler == ps_limit(s.ps_sel));

   // access phase: one wait state, write lands on the pready edge
   assign rd_start = psel && penable && !s.pready;
   assign wr_take = psel && penable && s.pready && pwrite;

   always_comb
   begin
      next_s = s;
      next_s.prefetch = 1'b0;
      next_s.resume = 1'b0;
      next_s.vector_req = 1'b0;
      next_s.wdt_reset = 1'b0;

      // apb handshake
      next_s.pready = rd_start;
      next_s.pslverr = rd_start && !mapped(paddr);
      if (rd_start && !pwrite)
      begin
         next_s.prdata = read_reg(paddr, s);
      end
      else if (rd_start)
      begin
         next_s.prdata = 32'h0;
      end

      // flags: sources set, software writes one to clear, set wins
      next_s.flag = s.flag;
      if (wr_take && (paddr == flag_addr) && pstrb[0])
      begin
         next_s.flag = s.flag & ~pwdata[num_sources-1:0];
      end
      next_s.flag = next_s.flag | irq_event;

      if (wr_take && (paddr == ctrl_addr))
      begin
         if (pstrb[0])
         begin
            next_s.global_interrupt_enable = pwdata[ctrl_gie_bit];
            next_s.enable = pwdata[ctrl_ie_lsb +: num_sources];
            next_s.crystal = pwdata[ctrl_crystal_bit];
            next_s.wdt_en = pwdata[ctrl_wdt_en_bit];
            next_s.ps_sel[0] = pwdata[ctrl_ps_lsb];
         end
         if (pstrb[1])
         begin
            next_s.ps_sel[2:1] = pwdata[ctrl_ps_lsb+2:ctrl_ps_lsb+1];
         end
      end

      // watchdog runs in every phase
      if (s.wdt_en)
      begin
         next_s.watchdog_counter = wdt_wrap ? 18'h0 :
                                   s.watchdog_counter + 18'h1;
         if (wdt_wrap)
         begin
            next_s.postscaler = wdt_timeout ? 8'h0 :
                                s.postscaler + 8'h1;
         end
      end
      if (wdt_timeout)
      begin
         next_s.timeout_status_flag = 1'b0;
         next_s.wdt_reset = (s.phase == awake);
      end

      if (clrwdt_exec && (s.phase == awake))
      begin
         next_s.watchdog_counter = 18'h0;
         next_s.postscaler = 8'h0;
         next_s.timeout_status_flag = 1'b1;
         next_s.powerdown_status_flag = 1'b1;
      end

      case (s.phase)
         awake:
         begin
            if (sleep_exec)
            begin
               next_s.prefetch = 1'b1;
               if (nop_cond)
               begin
                  // counts and flags untouched, pd stays set
                  next_s.skipped = 1'b1;
               end
               else
               begin
                  next_s.skipped = 1'b0;
                  next_s.watchdog_counter = 18'h0;
                  next_s.postscaler = 8'h0;
                  next_s.timeout_status_flag = 1'b1;
                  next_s.powerdown_status_flag = 1'b0;
                  next_s.core_hold = 1'b1;
                  next_s.phase = asleep;
               end
            end
         end
         asleep:
         begin
            // sleep already complete: leave on the first pending cycle
            if (wake_cond || wdt_timeout)
            begin
               next_s.ost_count = 11'h0;
               next_s.phase = s.crystal ? osc_wait : waking;
            end
         end
         osc_wait:
         begin
            next_s.ost_count = s.ost_count + 11'h1;
            if (s.ost_count == 11'(ost_cycles - 1))
            begin
               next_s.phase = waking;
            end
         end
         waking:
         begin
            // prefetched instruction runs first, then the vector
            next_s.resume = 1'b1;
            next_s.vector_req = s.global_interrupt_enable;
            next_s.core_hold = 1'b0;
            next_s.phase = awake;
         end
         default:
         begin
            next_s.phase = awake;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.phase <= awake;
         s.global_interrupt_enable <= ctrl_reset[ctrl_gie_bit];
         s.enable <= ctrl_reset[ctrl_ie_lsb +: num_sources];
         s.crystal <= ctrl_reset[ctrl_crystal_bit];
         s.wdt_en <= ctrl_reset[ctrl_wdt_en_bit];
         s.ps_sel <= ctrl_reset[ctrl_ps_lsb +: 3];
         s.timeout_status_flag <= timeout_reset;
         s.powerdown_status_flag <= pd_reset;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign prdata = s.prdata;
   assign prefetch_next = s.prefetch;
   assign resume_next = s.resume;
   assign branch_vector = s.vector_req;
   assign watchdog_reset = s.wdt_reset;
   assign core_hold = s.core_hold;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_sleep_taken;
      sleep_exec && (s.phase == awake) && !clrwdt_exec;
   endsequence

   sequence seq_real_sleep;
      seq_sleep_taken ##0 !nop_cond;
   endsequence

   sequence seq_skip_sleep;
      seq_sleep_taken ##0 nop_cond;
   endsequence

   sequence seq_rc_wake;
      (s.phase == asleep) && wake_cond && !s.crystal;
   endsequence

   a_gie_set_sleeps: assert property (
      seq_sleep_taken ##0 s.global_interrupt_enable |=>
         s.phase == asleep && core_hold)
      else $error("sleep with global enable set did not sleep");

   a_skip_no_sleep: assert property (
      seq_skip_sleep |=> s.phase == awake && !core_hold && s.skipped)
      else $error("skipped sleep entered low power");

   a_skip_keeps_flags: assert property (
      seq_skip_sleep ##0 !wdt_wrap |=>
         s.timeout_status_flag == $past(s.timeout_status_flag) &&
         s.postscaler == $past(s.postscaler) &&
         s.watchdog_counter ==
            $past(s.watchdog_counter) + 18'($past(s.wdt_en)))
      else $error("skipped sleep disturbed watchdog or timeout");

   a_skip_pd_set: assert property (
      seq_skip_sleep ##0 s.powerdown_status_flag |=>
         s.powerdown_status_flag [*2])
      else $error("powerdown flag lost after skipped sleep");

   a_sleep_clears: assert property (
      seq_real_sleep |=> s.watchdog_counter == 18'h0 &&
         s.postscaler == 8'h0 && s.timeout_status_flag &&
         !s.powerdown_status_flag)
      else $error("real sleep did not update watchdog and flags");

   a_wake_at_once: assert property (
      seq_rc_wake |=> s.phase == waking ##1 resume_next && !core_hold)
      else $error("rc wake did not follow pending condition");

   a_wake_vector: assert property (
      s.phase == waking |=>
         resume_next && branch_vector == $past(s.global_interrupt_enable))
      else $error("wake resume or vector wrong");

   a_prefetch_pulse: assert property (
      seq_sleep_taken |=> prefetch_next ##1 !prefetch_next)
      else $error("no prefetch during sleep");

   a_crystal_wait: assert property (
      (s.phase == asleep) && wake_cond && s.crystal |=>
         (s.phase == osc_wait && !resume_next) [*8])
      else $error("crystal wake skipped start-up wait");

endmodule
`default_nettype wire

/* verilog/sleep_wake_pkg.sv */
// constants, register map and state types of the sleep and wake control
`default_nettype none
package sleep_wake_pkg;

   // apb register byte addresses
   localparam logic [7:0] ctrl_addr   = 8'h00;
   localparam logic [7:0] flag_addr   = 8'h04;
   localparam logic [7:0] status_addr = 8'h08;
   localparam logic [7:0] wdt_addr    = 8'h0c;

   // control register fields
   localparam int ctrl_gie_bit     = 0;
   localparam int ctrl_ie_lsb      = 1;
   localparam int ctrl_crystal_bit = 5;
   localparam int ctrl_wdt_en_bit  = 6;
   localparam int ctrl_ps_lsb      = 7;

   // status register fields
   localparam int stat_timeout_bit   = 0;
   localparam int stat_powerdown_bit = 1;
   localparam int stat_sleeping_bit  = 2;
   localparam int stat_skipped_bit   = 3;

   // reset values
   localparam logic [9:0] ctrl_reset    = 10'h040;
   localparam logic       timeout_reset = 1'b1;
   localparam logic       pd_reset      = 1'b1;

   // timing: core clock and watchdog period
   localparam int clk_period_ns   = 100;
   localparam int wdt_period_ns   = 18000000;
   localparam int wdt_period_cyc  = wdt_period_ns / clk_period_ns;
   localparam int ost_cycles      = 1024;

   localparam int num_sources = 4;

   typedef enum logic [1:0] {awake, asleep, osc_wait, waking} phase_type;

   typedef struct packed {
      phase_type                phase;
      logic                     global_interrupt_enable;
      logic [num_sources-1:0]   enable;
      logic                     crystal;
      logic                     wdt_en;
      logic [2:0]               ps_sel;
      logic [num_sources-1:0]   flag;
      logic                     timeout_status_flag;
      logic                     powerdown_status_flag;
      logic                     skipped;
      logic [17:0]              watchdog_counter;
      logic [7:0]               postscaler;
      logic [10:0]              ost_count;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
      logic                     prefetch;
      logic                     resume;
      logic                     vector_req;
      logic                     wdt_reset;
      logic                     core_hold;
   } state_type;

endpackage
`default_nettype wire

/* tb/seq_model.sv */
// sequencer and interrupt source model facing the sleep control
`timescale 1ns/1ps
`default_nettype none
module seq_model
   import sleep_wake_pkg::*;
(
   input  wire logic              pclk,
   output logic                   sleep_exec,
   output logic                   clrwdt_exec,
   output logic [num_sources-1:0] irq_event,
   input  wire logic              prefetch_next,
   input  wire logic              resume_next,
   input  wire logic              branch_vector,
   input  wire logic              core_hold
);
   initial
   begin
      sleep_exec  = 1'b0;
      clrwdt_exec = 1'b0;
      irq_event   = '0;
   end
   // one sleep instruction; prefetch and hold seen the cycle after
   task automatic do_sleep(output logic pf, output logic hold);
      @(posedge pclk) sleep_exec <= 1'b1;
      @(posedge pclk) sleep_exec <= 1'b0;
      #1;
      pf = prefetch_next;
      hold = core_hold;
   endtask
   task automatic do_clrwdt();
      @(posedge pclk) clrwdt_exec <= 1'b1;
      @(posedge pclk) clrwdt_exec <= 1'b0;
   endtask
   task automatic raise_irq(input int src);
      @(posedge pclk) irq_event[src] <= 1'b1;
      @(posedge pclk) irq_event[src] <= 1'b0;
   endtask
   // cycles until resume, -1 if it does not come within 1200 cycles
   task automatic wait_resume(output int cyc, output logic vec);
      cyc = -1;
      vec = 1'b0;
      for (int i = 1; i <= 1200 && cyc < 0; i++)
      begin
         @(posedge pclk) #1;
         if (resume_next === 1'b1)
         begin
            cyc = i;
            vec = branch_vector;
         end
      end
   endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the sleep and wake control
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import sleep_wake_pkg::*;
;
   logic                   pclk;
   logic                   presetn;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [7:0]             paddr;
   logic [31:0]            pwdata;
   logic                   pready;
   logic                   pslverr;
   logic [31:0]            prdata;
   logic [num_sources-1:0] irq_event;
   logic                   sleep_exec;
   logic                   clrwdt_exec;
   logic                   prefetch_next;
   logic                   resume_next;
   logic                   branch_vector;
   logic                   core_hold;
   logic                   watchdog_reset;
   int                     n_errors;
   int                     checked;

   sleep_wake_interrupt_control #(.wdt_cycles(4096)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .irq_event(irq_event), .sleep_exec(sleep_exec),
      .clrwdt_exec(clrwdt_exec), .prefetch_next(prefetch_next),
      .resume_next(resume_next), .branch_vector(branch_vector),
      .watchdog_reset(watchdog_reset), .core_hold(core_hold));

   seq_model p (
      .pclk(pclk), .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec),
      .irq_event(irq_event), .prefetch_next(prefetch_next),
      .resume_next(resume_next), .branch_vector(branch_vector),
      .core_hold(core_hold));

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         n_errors++;
         report_and_stop();
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic e;
      apb(1'b0, a, 32'h0, v, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, v, r, e);
   endtask

   task automatic t_reset();
      logic [31:0] v;
      logic        e;
      rd(ctrl_addr, v);
      chk(v, 32'h0000_0040);
      rd(status_addr, v);
      chk(v, 32'h0000_0003);
      apb(1'b0, 8'h1c, 32'h0, v, e);
      chk({31'h0, e}, 32'h1);
      $display("test reset done");
   endtask

   // flag pending before sleep with global enable clear
   task automatic t_skip();
      logic [31:0] w0;
      logic [31:0] v;
      logic        pf;
      logic        h;
      wr(ctrl_addr, 32'h0000_0002);
      p.raise_irq(0);
      rd(wdt_addr, w0);
      p.do_sleep(pf, h);
      chk({31'h0, pf}, 32'h1);
      chk({31'h0, h}, 32'h0);
      rd(status_addr, v);
      chk(v, 32'h0000_000b);
      rd(wdt_addr, v);
      chk(v, w0);
      $display("test skipped sleep done");
   endtask

   // real sleep, then wake by interrupt
   task automatic t_wake(input logic [31:0] c, input logic vexp);
      logic [31:0] v;
      logic        pf;
      logic        h;
      logic        vec;
      int          cyc;
      wr(flag_addr, 32'h0000_000f);
      wr(ctrl_addr, c);
      p.do_sleep(pf, h);
      chk({31'h0, h}, 32'h1);
      rd(status_addr, v);
      chk(v, 32'h0000_0005);
      rd(wdt_addr, v);
      chk(v, 32'h0);
      p.raise_irq(0);
      p.wait_resume(cyc, vec);
      chk({31'h0, cyc > 0}, 32'h1);
      if (cyc < 0)
         report_and_stop();
      if (c[ctrl_crystal_bit])
         chk({31'h0, cyc >= ost_cycles}, 32'h1);
      else
         chk({31'h0, cyc <= 4}, 32'h1);
      chk({31'h0, vec}, {31'h0, vexp});
      #1;
      chk({31'h0, core_hold}, 32'h0);
      rd(status_addr, v);
      chk(v, 32'h0000_0001);
      $display("test wake done");
   endtask

   // watchdog timeout while awake, then clear and a skipped sleep
   task automatic t_wdt();
      logic [31:0] v;
      logic [31:0] w;
      logic        pf;
      logic        h;
      int          cyc;
      cyc = 0;
      wr(ctrl_addr, 32'h0000_0040);
      for (int i = 1; i <= 4200 && cyc == 0; i++)
      begin
         @(posedge pclk) #1;
         if (watchdog_reset === 1'b1)
            cyc = i;
      end
      chk({31'h0, cyc >= 4000}, 32'h1);
      if (cyc == 0)
         report_and_stop();
      rd(status_addr, v);
      chk(v, 32'h0000_0000);
      p.do_clrwdt();
      wr(ctrl_addr, 32'h0000_0042);
      rd(wdt_addr, w);
      p.do_sleep(pf, h);
      chk({31'h0, h}, 32'h0);
      rd(status_addr, v);
      chk(v, 32'h0000_000b);
      rd(wdt_addr, v);
      chk({31'h0, v > w}, 32'h1);
      $display("test watchdog done");
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial
   begin
      n_errors = 0;
      checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_skip();
      t_wake(32'h0000_0002, 1'b0);
      t_wake(32'h0000_0023, 1'b1);
      t_wdt();
      report_and_stop();
   end
endmodule
`default_nettype wire
